// ---- src/rcf_event_cond.sv ----
`timescale 1ns/1ps
// Turns raw reset-source pulses into set and clear masks for the flags
module rcf_event_cond
   import rcf_pkg::*;
(
   input  wire logic  stack_overflow,              // Stack overflow pulse
   input  wire logic  stack_underflow,             // Stack underflow pulse
   input  wire logic  stack_reset_enable,          // Stack resets enabled
   input  wire logic  watchdog_timeout,            // Watchdog timeout reset pulse
   input  wire logic  external_clear_pin_reset,    // Reset through the clear pin
   input  wire logic  reset_instruction,           // Reset instruction executed
   input  wire logic  brownout_detector,           // Normal brown-out detector reset
   input  wire logic  low_power_brownout_detector, // Low-power brown-out detector reset
   rcf_evt_if.source  evt                          // Update masks to the register
);

   logic brownout_any;  // Generic brown-out reset

   ////////////////////////////////////////////////////////////////////////////////
   // Mask building
   always_comb begin
      // Either detector counts as a brown-out
      brownout_any = brownout_detector | low_power_brownout_detector;
      evt.set_bits   = 8'h00;
      evt.clear_bits = 8'h00;
      // Stack causes only count when stack resets are enabled
      evt.set_bits[BIT_STACK_OVERFLOW]  = stack_overflow & stack_reset_enable;
      evt.set_bits[BIT_STACK_UNDERFLOW] = stack_underflow & stack_reset_enable;
      evt.clear_bits[BIT_WATCHDOG]      = watchdog_timeout;
      evt.clear_bits[BIT_CLEAR_PIN]     = external_clear_pin_reset;
      evt.clear_bits[BIT_RESET_INSTR]   = reset_instruction;
      evt.clear_bits[BIT_BROWNOUT]      = brownout_any;
      // A brown-out initialises all flags but the power-on flag as power-on does
      if (brownout_any) begin
         evt.clear_bits[BIT_STACK_OVERFLOW]  = 1'b1;
         evt.clear_bits[BIT_STACK_UNDERFLOW] = 1'b1;
         evt.set_bits[BIT_STACK_OVERFLOW]    = 1'b0;
         evt.set_bits[BIT_STACK_UNDERFLOW]   = 1'b0;
         evt.set_bits[BIT_WATCHDOG]          = 1'b1;
         evt.set_bits[BIT_CLEAR_PIN]         = 1'b1;
         evt.set_bits[BIT_RESET_INSTR]       = 1'b1;
         evt.clear_bits[BIT_WATCHDOG]        = 1'b0;
         evt.clear_bits[BIT_CLEAR_PIN]       = 1'b0;
         evt.clear_bits[BIT_RESET_INSTR]     = 1'b0;
      end
      // Interrupt events follow the flag layout
      evt.event_bits = 8'h00;
      evt.event_bits[BIT_STACK_OVERFLOW]  = stack_overflow & stack_reset_enable;
      evt.event_bits[BIT_STACK_UNDERFLOW] = stack_underflow & stack_reset_enable;
      evt.event_bits[BIT_WATCHDOG]        = watchdog_timeout;
      evt.event_bits[BIT_CLEAR_PIN]       = external_clear_pin_reset;
      evt.event_bits[BIT_RESET_INSTR]     = reset_instruction;
      evt.event_bits[BIT_BROWNOUT]        = brownout_any;
   end

endmodule  // rcf_event_cond

// ---- src/rcf_evt_if.sv ----
`timescale 1ns/1ps
// Hardware update lines from the event conditioner to the flag register and the interrupt status
interface rcf_evt_if;
   logic [7:0] set_bits;    // Flags that hardware sets this cycle
   logic [7:0] clear_bits;  // Flags that hardware clears this cycle
   logic [7:0] event_bits;  // One bit per event, same layout, for the interrupt status

   modport source (output set_bits, output clear_bits, output event_bits);
   modport sink   (input set_bits, input clear_bits, input event_bits);
endinterface

// ---- src/rcf_irq.sv ----
`timescale 1ns/1ps
// Sticky event status, mask and level interrupt
module rcf_irq
   import rcf_pkg::*;
#(
   parameter int unsigned WIDTH = 8  // Status width
)
(
   input  wire logic             clock,         // Core clock
   input  wire logic             reset,         // Asynchronous reset, active high
   input  wire logic [WIDTH-1:0] events,        // Event pulses
   input  wire logic             status_write,  // Write-one-to-clear strobe
   input  wire logic             mask_write,    // Mask write strobe
   input  wire logic [WIDTH-1:0] write_data,    // Write data
   output logic      [WIDTH-1:0] status,        // Sticky status
   output logic      [WIDTH-1:0] mask,          // Interrupt mask
   output logic                  irq            // Level interrupt
);

   typedef struct packed {
      logic [WIDTH-1:0] status;  // Sticky bits
      logic [WIDTH-1:0] mask;    // Enables
      logic             irq;     // Registered interrupt
   } rcf_irq_state_type;

   rcf_irq_state_type state;       // Current state
   rcf_irq_state_type next_state;  // Next state

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_state = state;
      // Clear first so a same-cycle event still sets its bit
      if (status_write) begin
         next_state.status = state.status & ~write_data;
      end
      next_state.status = (next_state.status | events) & EVENT_IMPL_MASK[WIDTH-1:0];
      if (mask_write) begin
         next_state.mask = write_data & EVENT_IMPL_MASK[WIDTH-1:0];
      end
      // Registering the OR keeps the output glitch free
      next_state.irq = |(next_state.status & next_state.mask);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= '{status: STATUS_RESET_VALUE[WIDTH-1:0], mask: MASK_RESET_VALUE[WIDTH-1:0], irq: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign status = state.status;
   assign mask   = state.mask;
   assign irq    = state.irq;

endmodule  // rcf_irq

// ---- src/rcf_pkg.sv ----
// Shared constants for the reset-cause flag block
package rcf_pkg;

   // Data and address widths of the register port
   localparam int unsigned DATA_WIDTH = 8;
   localparam int unsigned ADDR_WIDTH = 4;

   // Register offsets on the plain register port
   localparam logic [3:0] OFFSET_CAUSE  = 4'h0;  // Reset-cause register
   localparam logic [3:0] OFFSET_STATUS = 4'h1;  // Sticky event status, write one to clear
   localparam logic [3:0] OFFSET_MASK   = 4'h2;  // Interrupt mask, one enables

   // Bit positions inside the reset-cause register
   localparam int unsigned BIT_STACK_OVERFLOW  = 7;
   localparam int unsigned BIT_STACK_UNDERFLOW = 6;
   localparam int unsigned BIT_UNUSED          = 5;
   localparam int unsigned BIT_WATCHDOG        = 4;
   localparam int unsigned BIT_CLEAR_PIN       = 3;
   localparam int unsigned BIT_RESET_INSTR     = 2;
   localparam int unsigned BIT_POWER_ON        = 1;
   localparam int unsigned BIT_BROWNOUT        = 0;

   // Value after power-on reset: stack flags 0, watchdog/pin/instr 1, power-on 0, brown-out 0
   localparam logic [7:0] CAUSE_RESET_VALUE = 8'h1c;

   // Bits that exist and are writable; bit 5 is absent
   localparam logic [7:0] CAUSE_IMPL_MASK = 8'hdf;

   // Bits of the status and mask registers that can ever be set
   localparam logic [7:0] EVENT_IMPL_MASK = 8'hdd;

   // Reset values of the interrupt registers and the read data
   localparam logic [7:0] STATUS_RESET_VALUE = 8'h00;
   localparam logic [7:0] MASK_RESET_VALUE   = 8'h00;
   localparam logic [7:0] RDATA_RESET_VALUE  = 8'h00;

endpackage

// ---- src/rcf_top.sv ----
`timescale 1ns/1ps
module rcf_top
   import rcf_pkg::*;
(
   input  wire logic                         clock,                        // Core clock, 25 MHz
   input  wire logic                         reset,                        // Power-on reset, async, high
   input  wire logic [rcf_pkg::ADDR_WIDTH-1:0] address,                    // Register address
   input  wire logic [rcf_pkg::DATA_WIDTH-1:0] write_data,                 // Register write data
   input  wire logic                         write_strobe,                 // One-cycle write
   input  wire logic                         read_strobe,                  // One-cycle read
   input  wire logic                         stack_overflow,               // Stack overflow pulse
   input  wire logic                         stack_underflow,              // Stack underflow pulse
   input  wire logic                         stack_reset_enable,           // Stack reset option
   input  wire logic                         watchdog_timeout,             // Watchdog reset pulse
   input  wire logic                         external_clear_pin_reset,     // Clear-pin reset pulse
   input  wire logic                         reset_instruction,            // Reset instruction pulse
   input  wire logic                         brownout_detector,            // Normal brown-out pulse
   input  wire logic                         low_power_brownout_detector,  // Low-power brown-out pulse
   output logic      [rcf_pkg::DATA_WIDTH-1:0] read_data,                  // Read data, cycle after strobe
   output logic      [rcf_pkg::DATA_WIDTH-1:0] reset_cause_register,       // Live flag value
   output logic                              irq                           // Level interrupt
);
   import rcf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [DATA_WIDTH-1:0] cause;  // Flag register
      logic [DATA_WIDTH-1:0] rdata;  // Registered read data
   } rcf_top_state_type;

   rcf_top_state_type state;       // Current state
   rcf_top_state_type next_state;  // Next state

   rcf_evt_if evt ();                     // Hardware update lines
   logic [DATA_WIDTH-1:0] irq_status;     // Sticky event status
   logic [DATA_WIDTH-1:0] irq_mask;       // Interrupt mask
   logic                  status_write;   // Status register hit
   logic                  mask_write;     // Mask register hit
   logic                  cause_write;    // Cause register hit

   ////////////////////////////////////////////////////////////////////////////////
   // Event conditioning
   rcf_event_cond u_event_cond (
      .stack_overflow              (stack_overflow),
      .stack_underflow             (stack_underflow),
      .stack_reset_enable          (stack_reset_enable),
      .watchdog_timeout            (watchdog_timeout),
      .external_clear_pin_reset    (external_clear_pin_reset),
      .reset_instruction           (reset_instruction),
      .brownout_detector           (brownout_detector),
      .low_power_brownout_detector (low_power_brownout_detector),
      .evt                         (evt.source)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   always_comb begin
      cause_write  = write_strobe && (address == OFFSET_CAUSE);
      status_write = write_strobe && (address == OFFSET_STATUS);
      mask_write   = write_strobe && (address == OFFSET_MASK);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask
   rcf_irq #(
      .WIDTH (DATA_WIDTH)
   ) u_irq (
      .clock        (clock),
      .reset        (reset),
      .events       (evt.event_bits),
      .status_write (status_write),
      .mask_write   (mask_write),
      .write_data   (write_data),
      .status       (irq_status),
      .mask         (irq_mask),
      .irq          (irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic for the flags and the read data
   always_comb begin
      next_state = state;
      // Firmware write lands first; absent bit 5 never takes a one
      if (cause_write) begin
         next_state.cause = write_data & CAUSE_IMPL_MASK;
      end
      // Hardware applied last so a reset cause is never lost to a write
      next_state.cause = (next_state.cause & ~evt.clear_bits) | evt.set_bits;
      next_state.cause = next_state.cause & CAUSE_IMPL_MASK;
      // Reads return data one cycle later, zero elsewhere
      next_state.rdata = RDATA_RESET_VALUE;
      if (read_strobe) begin
         case (address)
            OFFSET_CAUSE: begin
               next_state.rdata = state.cause;
            end
            OFFSET_STATUS: begin
               next_state.rdata = irq_status;
            end
            OFFSET_MASK: begin
               next_state.rdata = irq_mask;
            end
            default: begin
               next_state.rdata = RDATA_RESET_VALUE;  // Unmapped reads as zero
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; power-on loads the default flag pattern
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= '{cause: CAUSE_RESET_VALUE, rdata: RDATA_RESET_VALUE};
      end else begin
         state <= next_state;
      end
   end

   assign read_data            = state.rdata;
   assign reset_cause_register = state.cause;

endmodule  // rcf_top

// ---- testbench/rcf_top_asserts.sv ----
`timescale 1ns/1ps
// Watches the flag block at its pins only
module rcf_top_asserts
   import rcf_pkg::*;
(
   input wire logic                              clock,
   input wire logic                              reset,
   input wire logic [rcf_pkg::ADDR_WIDTH-1:0]   address,
   input wire logic [rcf_pkg::DATA_WIDTH-1:0]   write_data,
   input wire logic                              write_strobe,
   input wire logic                              read_strobe,
   input wire logic                              stack_overflow,
   input wire logic                              stack_underflow,
   input wire logic                              stack_reset_enable,
   input wire logic                              watchdog_timeout,
   input wire logic                              external_clear_pin_reset,
   input wire logic                              reset_instruction,
   input wire logic                              brownout_detector,
   input wire logic                              low_power_brownout_detector,
   input wire logic [rcf_pkg::DATA_WIDTH-1:0]   read_data,
   input wire logic [rcf_pkg::DATA_WIDTH-1:0]   reset_cause_register,
   input wire logic                              irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   // Brown-out overrides every other source in the flags, so most checks exclude it
   wire logic bod   = brownout_detector | low_power_brownout_detector;
   wire logic wr0   = write_strobe && (address == 4'h0);
   wire logic quiet = !(stack_overflow | stack_underflow | watchdog_timeout | external_clear_pin_reset
                        | reset_instruction | bod);
   // Only an event or a mask write can raise the interrupt; a status write only lowers it
   wire logic irq_src = !quiet || (write_strobe && (address == 4'h2));
   ////////////////////////////////////////////////////////////////////////
   property p_gap_zero; reset_cause_register[5] == 1'b0; endproperty
   a_gap_zero: assert property (p_gap_zero) else $error("gap bit set");
   property p_ovf_set; stack_overflow && stack_reset_enable && !bod |=> reset_cause_register[7]; endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");
   property p_stack_off; stack_overflow && !stack_reset_enable && !wr0 && !bod |=> $stable(reset_cause_register[7]);
   endproperty
   a_stack_off: assert property (p_stack_off) else $error("overflow flag moved while disabled");
   property p_hold; quiet && !wr0 |=> $stable(reset_cause_register); endproperty
   a_hold: assert property (p_hold) else $error("flags moved with no cause");
   property p_write; wr0 && quiet |=> reset_cause_register == ($past(write_data) & 8'hdf); endproperty
   a_write: assert property (p_write) else $error("firmware write lost");
   property p_bod; bod |=> (reset_cause_register & 8'hfd) == 8'h1c; endproperty
   a_bod: assert property (p_bod) else $error("brown-out pattern wrong");
   property p_read; read_strobe && (address == 4'h0) |=> read_data == $past(reset_cause_register); endproperty
   a_read: assert property (p_read) else $error("read data wrong");
   property p_wdt; watchdog_timeout && !bod |=> !reset_cause_register[4]; endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog flag not cleared");
   property p_pin; external_clear_pin_reset && !bod |=> !reset_cause_register[3]; endproperty
   a_pin: assert property (p_pin) else $error("clear-pin flag not cleared");
   property p_unf_set; stack_underflow && stack_reset_enable && !bod |=> reset_cause_register[6]; endproperty
   a_unf_set: assert property (p_unf_set) else $error("underflow flag not set");
   property p_instr; reset_instruction && !bod |=> !reset_cause_register[2]; endproperty
   a_instr: assert property (p_instr) else $error("instruction flag not cleared");
   property p_irq_src; $rose(irq) |-> $past(irq_src); endproperty
   a_irq_src: assert property (p_irq_src) else $error("interrupt rose with no event or mask write");
endmodule // rcf_top_asserts

bind rcf_top rcf_top_asserts u_asserts (.clock(clock), .reset(reset), .address(address),
   .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
   .stack_overflow(stack_overflow), .stack_underflow(stack_underflow), .stack_reset_enable(stack_reset_enable),
   .watchdog_timeout(watchdog_timeout), .external_clear_pin_reset(external_clear_pin_reset),
   .reset_instruction(reset_instruction), .brownout_detector(brownout_detector),
   .low_power_brownout_detector(low_power_brownout_detector), .read_data(read_data),
   .reset_cause_register(reset_cause_register), .irq(irq));

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
// Self-checking bench: a cycle model runs beside the block
module tb;
   import rcf_pkg::*;
   logic       clock, reset, write_strobe, read_strobe, en;
   logic [3:0] address;
   logic [7:0] write_data;
   logic [7:0] ev;                      // 0 ovf,1 unf,2 wdt,3 pin,4 instr,5 bod,6 low-power bod
   wire  logic [7:0] read_data, cause;
   wire  logic irq;
   logic [7:0] m_cause, m_status, m_mask, m_rd, e, c;  // Model state
   int         fail_count, check_count, cycles, r, op;

   rcf_top dut (.clock(clock), .reset(reset), .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .stack_overflow(ev[0]), .stack_underflow(ev[1]),
      .stack_reset_enable(en), .watchdog_timeout(ev[2]), .external_clear_pin_reset(ev[3]),
      .reset_instruction(ev[4]), .brownout_detector(ev[5]), .low_power_brownout_detector(ev[6]),
      .read_data(read_data), .reset_cause_register(cause), .irq(irq));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   // Model reads inputs before this edge's updates land
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         m_cause = 8'h1c; m_status = 8'h00; m_mask = 8'h00; m_rd = 8'h00;
      end else begin
         m_rd = !read_strobe ? 8'h00 : address == 4'h0 ? m_cause : address == 4'h1 ? m_status :
                address == 4'h2 ? m_mask : 8'h00;
         e = {ev[0] & en, ev[1] & en, 1'b0, ev[2], ev[3], ev[4], 1'b0, ev[5] | ev[6]};
         c = (write_strobe && address == 4'h0) ? (write_data & 8'hdf) : m_cause;
         c = (c | (e & 8'hc0)) & ~(e & 8'h1c);   // Event beats a same-cycle write
         if (e[0]) c = {5'b00011, 1'b1, c[1], 1'b0};
         m_cause = c;
         m_status = (m_status & ~((write_strobe && address == 4'h1) ? write_data : 8'h00)) | e;
         if (write_strobe && address == 4'h2) m_mask = write_data & 8'hdd;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
      check_count++;
      if (s !== x) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Compare every settled cycle; a hang ends the run
   always @(negedge clock) begin
      chk("cause", m_cause, cause);
      chk("read_data", m_rd, read_data);
      chk("irq", {7'h00, |(m_status & m_mask)}, {7'h00, irq});
      cycles++;
      if (cycles >= 3000) begin
         fail_count++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // One bus cycle; the leading wait keeps strobes from being set twice at an edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      address <= a; write_data <= d; write_strobe <= w; read_strobe <= !w;
      @(posedge clock);
      write_strobe <= 1'b0; read_strobe <= 1'b0;
   endtask

   task automatic pulse(input logic [7:0] v);
      @(posedge clock);
      ev <= v;
      @(posedge clock);
      ev <= 8'h00;
   endtask

   initial begin
      reset = 1'b1; address = 4'h0; write_data = 8'h00; write_strobe = 1'b0; read_strobe = 1'b0;
      ev = 8'h00; en = 1'b0; fail_count = 0; check_count = 0; cycles = 0;
      void'($urandom(90735));
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      bus(1'b1, 4'h0, 8'hff);
      bus(1'b1, 4'h2, 8'hff);
      for (int k = 0; k < 2; k++) begin       // Stack resets off, then on
         en <= k[0];
         for (int i = 0; i < 7; i++) begin
            pulse(8'h01 << i);
            bus(1'b0, 4'h1, 8'h00);
            bus(1'b1, 4'h1, 8'hff);
            bus(1'b1, 4'h0, 8'hff);
         end
      end
      @(posedge clock);
      ev <= 8'h05; address <= 4'h0; write_data <= 8'h10; write_strobe <= 1'b1;
      @(posedge clock);
      ev <= 8'h00; write_strobe <= 1'b0;
      pulse(8'h64);
      bus(1'b1, 4'h2, 8'h00);
      pulse(8'h08);
      bus(1'b1, 4'h7, 8'hff);
      bus(1'b0, 4'h5, 8'h00);
      // Random traffic: rare events, back-to-back bus cycles, unmapped places
      for (int i = 0; i < 600; i++) begin
         @(posedge clock);
         r = $urandom % 24;
         op = $urandom % 3;
         ev <= (r < 7) ? (8'h01 << r) : 8'h00;
         en <= 1'($urandom % 2);
         address <= 4'($urandom % 5);
         write_data <= 8'($urandom);
         write_strobe <= (op == 0);
         read_strobe <= (op == 1);
      end
      @(posedge clock);
      ev <= 8'h00; write_strobe <= 1'b0; read_strobe <= 1'b0;
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      bus(1'b0, 4'h0, 8'h00);
      repeat (3) @(posedge clock);
      finish_test();
   end
endmodule // tb
